// ===== dv/tb_core_status_pc_stack.sv
// Self-checking bench for the core flag, config, pc and stack block.
// Drives the register port, execution port, events and pins directly.
`timescale 1ns/1ns
`default_nettype none
module tb_core_status_pc_stack
	import core_sfr_pkg::*;
();
	logic              mclk;
	logic              nrst;
	logic [ADDR_W-1:0] reg_addr;
	logic [7:0]        reg_wdata;
	logic              reg_wr;
	logic              reg_rd;
	logic [7:0]        reg_rdata;
	exec_op_s          exec_op;
	logic [7:0]        fsr;
	logic [6:0]        dir_offset;
	logic [7:0]        alu_result;
	logic [PC_W-1:0]   pc_out;
	data_addr_s        data_addr;
	logic              wdt_timeout;
	logic              bor_event;
	logic              other_reset;
	logic              timer0_ext_clock_pin;
	logic              ext_interrupt_pin;
	logic              instr_tick;
	logic              wdt_base_tick;
	logic [7:0]        pullup_enable_mask;
	logic [7:0]        pullup_en;
	logic              timer0_inc;
	logic              wdt_tick;
	logic              ext_irq;
	int                err_total;
	int                samples_checked;
	int                inc_cnt;
	int                wdt_cnt;
	int                irq_cnt;

	core_status_pc_stack dut_u (
		.mclk                 (mclk),
		.nrst                 (nrst),
		.reg_addr             (reg_addr),
		.reg_wdata            (reg_wdata),
		.reg_wr               (reg_wr),
		.reg_rd               (reg_rd),
		.reg_rdata            (reg_rdata),
		.exec_op              (exec_op),
		.fsr                  (fsr),
		.dir_offset           (dir_offset),
		.alu_result           (alu_result),
		.pc_out               (pc_out),
		.data_addr            (data_addr),
		.wdt_timeout          (wdt_timeout),
		.bor_event            (bor_event),
		.other_reset          (other_reset),
		.timer0_ext_clock_pin (timer0_ext_clock_pin),
		.ext_interrupt_pin    (ext_interrupt_pin),
		.instr_tick           (instr_tick),
		.wdt_base_tick        (wdt_base_tick),
		.pullup_enable_mask   (pullup_enable_mask),
		.pullup_en            (pullup_en),
		.timer0_inc           (timer0_inc),
		.wdt_tick             (wdt_tick),
		.ext_irq              (ext_irq)
	);

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// Pulse counters
	always @(posedge mclk) begin
		if (timer0_inc === 1'b1) inc_cnt++;
		if (wdt_tick === 1'b1) wdt_cnt++;
		if (ext_irq === 1'b1) irq_cnt++;
	end

	task automatic end_sim;
		$display("Checks %0d, errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk_val(input logic [12:0] got, input logic [12:0] exp,
		input string what);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, what,
				got, exp);
		end
	endtask

	task automatic chk_cnt(input int got, input int exp, input string what);
		samples_checked++;
		if (got != exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t %s count %0d exp %0d", $time, what,
				got, exp);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [2:0] a, input logic [7:0] e,
		input logic [7:0] m = 8'hff);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		chk_val(reg_rdata & m, e & m, "register read");
	endtask

	task automatic ex(input op_kind_e k, input logic [7:0] a = 8'h00,
		input logic [7:0] b = 8'h00, input logic [7:0] lr = 8'h00,
		input logic ci = 1'b0, input logic [10:0] t = 11'h000,
		input logic sw = 1'b0, input logic [7:0] sd = 8'h00,
		input logic st = 1'b0);
		@(posedge mclk);
		exec_op   <= '{1'b1, k, a, b, lr, ci, t, st};
		reg_addr  <= REG_STATUS;
		reg_wdata <= sd;
		reg_wr    <= sw;
		@(posedge mclk);
		exec_op.valid <= 1'b0;
		reg_wr        <= 1'b0;
		#1;
	endtask

	task automatic pulse(input int w);
		@(posedge mclk);
		wdt_timeout <= (w == 0);
		bor_event   <= (w == 1);
		other_reset <= (w == 2);
		@(posedge mclk);
		{wdt_timeout, bor_event, other_reset} <= 3'b000;
		#1;
	endtask

	task automatic ticks(input int n, input logic w);
		repeat (n) begin
			@(posedge mclk);
			instr_tick    <= ~w;
			wdt_base_tick <= w;
			@(posedge mclk);
			instr_tick    <= 1'b0;
			wdt_base_tick <= 1'b0;
		end
		repeat (4) @(posedge mclk);
	endtask

	task automatic pin(input logic p, input logic v);
		@(posedge mclk);
		if (p) ext_interrupt_pin <= v;
		else timer0_ext_clock_pin <= v;
		repeat (8) @(posedge mclk);
	endtask

	task automatic clr;
		@(negedge mclk);
		inc_cnt = 0;
		wdt_cnt = 0;
		irq_cnt = 0;
	endtask

	initial begin
		#400000;
		err_total++;
		$display("CHECK FAILED t=%0t run did not finish", $time);
		end_sim;
	end

	initial begin
		{nrst, reg_wr, reg_rd, wdt_timeout, bor_event, other_reset} = '0;
		{timer0_ext_clock_pin, ext_interrupt_pin, instr_tick} = '0;
		{reg_addr, reg_wdata, wdt_base_tick, err_total} = '0;
		{samples_checked, inc_cnt, wdt_cnt, irq_cnt} = '0;
		exec_op = '0;
		fsr = 8'h34;
		dir_offset = 7'h12;
		pullup_enable_mask = 8'h5a;
		repeat (3) @(posedge mclk);
		nrst <= 1'b1;
		chk_val(pc_out, PC_RST, "pc after reset");
		rd(REG_STATUS, 8'h18);
		rd(REG_OPTION, 8'hff);
		rd(REG_POWER_FLAGS_REG, 8'h00);
		wr(3'h7, 8'h55);
		rd(3'h7, 8'h00);
		// Bank select codes and read-only flags
		for (int i = 0; i < 4; i++) begin
			wr(REG_STATUS, {i[0], i[1:0], 5'h07});
			rd(REG_STATUS, {i[0], i[1:0], 5'h1f});
			chk_val(data_addr.indirect, {i[0], fsr}, "indirect");
			chk_val(data_addr.direct, {i[1:0], dir_offset}, "direct");
		end
		wr(REG_STATUS, 8'h00);
		ex(OP_ADD, 8'h0f, 8'h01, 8'h00, 1'b0, 11'h0, 1'b1, 8'h07);
		chk_val(alu_result, 8'h10, "add");
		rd(REG_STATUS, 8'h1a);
		ex(OP_SUB, 8'h05, 8'h05);
		rd(REG_STATUS, 8'h07, 8'h07);
		ex(OP_SUB, 8'h00, 8'h01);
		chk_val(alu_result, 8'hff, "sub");
		rd(REG_STATUS, 8'h00, 8'h07);
		ex(OP_ADD, 8'h80, 8'h80);
		rd(REG_STATUS, 8'h05, 8'h07);
		ex(OP_RLF, 8'h81);
		chk_val(alu_result, 8'h02, "rotate left");
		rd(REG_STATUS, 8'h01, 8'h01);
		ex(OP_RRF, 8'h02, 8'h00, 8'h00, 1'b1);
		chk_val(alu_result, 8'h81, "rotate right");
		rd(REG_STATUS, 8'h00, 8'h01);
		ex(OP_LOGIC, 8'h00, 8'h00, 8'h00);
		rd(REG_STATUS, 8'h04, 8'h04);
		ex(OP_LOGIC, 8'h00, 8'h00, 8'h3c);
		rd(REG_STATUS, 8'h00, 8'h04);
		ex(OP_SLEEP);
		rd(REG_STATUS, 8'h10, 8'h18);
		pulse(0);
		rd(REG_STATUS, 8'h00, 8'h18);
		ex(OP_WATCHDOG_CLEAR_INSTR);
		rd(REG_STATUS, 8'h18, 8'h18);
		// Timer configuration side effects
		wr(REG_OPTION, 8'h5a);
		rd(REG_OPTION, 8'h5a);
		repeat (2) @(posedge mclk);
		chk_val(pullup_en, 8'h5a, "pullups on");
		wr(REG_OPTION, 8'hda);
		repeat (2) @(posedge mclk);
		chk_val(pullup_en, 8'h00, "pullups off");
		for (int e = 0; e < 2; e++) begin
			wr(REG_OPTION, {1'b1, e[0], 6'h08});
			clr;
			pin(1'b1, 1'b1);
			chk_cnt(irq_cnt, e, "irq rise");
			clr;
			pin(1'b1, 1'b0);
			chk_cnt(irq_cnt, 1 - e, "irq fall");
		end
		for (int s = 0; s < 2; s++) begin
			wr(REG_OPTION, {3'b101, s[0], 4'h8});
			clr;
			pin(1'b0, 1'b1);
			chk_cnt(inc_cnt, 1 - s, "t0 pin rise");
			clr;
			pin(1'b0, 1'b0);
			chk_cnt(inc_cnt, s, "t0 pin fall");
		end
		wr(REG_OPTION, 8'h88);
		clr;
		pin(1'b0, 1'b1);
		pin(1'b0, 1'b0);
		ticks(6, 1'b0);
		chk_cnt(inc_cnt, 6, "t0 internal");
		for (int p = 0; p < 8; p++) begin
			wr(REG_OPTION, {5'b10000, p[2:0]});
			clr;
			ticks(256, 1'b0);
			chk_cnt(inc_cnt, 256 >> (p + 1), "t0 prescale");
			wr(REG_OPTION, {5'b10001, p[2:0]});
			clr;
			ticks(256, 1'b1);
			chk_cnt(wdt_cnt, 256 >> p, "wdt prescale");
		end
		wr(REG_POWER_FLAGS_REG, 8'hff);
		rd(REG_POWER_FLAGS_REG, 8'h03);
		// Program counter and stack
		wr(REG_PC_HIGH_LATCH, 8'hff);
		rd(REG_PC_HIGH_LATCH, 8'h1f);
		wr(REG_PC_HIGH_LATCH, 8'h08);
		wr(REG_PCL, 8'h20);
		chk_val(pc_out, 13'h0820, "pc low write");
		rd(REG_PCL, 8'h20);
		ex(OP_CALL, 8'h00, 8'h00, 8'h00, 1'b0, 11'h100);
		chk_val(pc_out, 13'h0900, "call");
		ex(OP_RETURN);
		chk_val(pc_out, 13'h0820, "return");
		rd(REG_PC_HIGH_LATCH, 8'h08);
		ex(OP_IRQ);
		chk_val(pc_out, IRQ_VECTOR, "irq vector");
		ex(OP_RETURN);
		chk_val(pc_out, 13'h0820, "irq return");
		wr(REG_PC_HIGH_LATCH, 8'h18);
		ex(OP_JUMP, 8'h00, 8'h00, 8'h00, 1'b0, 11'h005);
		chk_val(pc_out, 13'h1805, "jump");
		ex(OP_NONE, 8'h00, 8'h00, 8'h00, 1'b0, 11'h000, 1'b0, 8'h00, 1'b1);
		chk_val(pc_out, 13'h1806, "step");
		// Call then return on the very next cycle
		@(posedge mclk);
		exec_op <= '{1'b1, OP_CALL, 8'h00, 8'h00, 8'h00, 1'b0, 11'h200, 1'b0};
		@(posedge mclk);
		exec_op.kind <= OP_RETURN;
		@(posedge mclk);
		exec_op.valid <= 1'b0;
		#1;
		chk_val(pc_out, 13'h1806, "call then return");
		wr(REG_PC_HIGH_LATCH, 8'h00);
		wr(REG_PCL, 8'hab);
		for (int i = 0; i < 9; i++)
			ex(OP_CALL, 8'h00, 8'h00, 8'h00, 1'b0, 11'h100 + i[10:0]);
		for (int k = 1; k < 9; k++) begin
			ex(OP_RETURN);
			chk_val(pc_out, 13'h108 - k[12:0], "stack pop");
		end
		ex(OP_RETURN);
		chk_val(pc_out, 13'h107, "stack wrap");
		// Reset events
		wr(REG_OPTION, 8'h00);
		ex(OP_SLEEP);
		pulse(1);
		chk_val(pc_out, PC_RST, "pc after brownout");
		rd(REG_POWER_FLAGS_REG, 8'h02);
		rd(REG_STATUS, 8'h18, 8'hf8);
		rd(REG_OPTION, 8'hff);
		wr(REG_PC_HIGH_LATCH, 8'h03);
		wr(REG_PCL, 8'h44);
		pulse(2);
		chk_val(pc_out, PC_RST, "pc after other reset");
		rd(REG_PC_HIGH_LATCH, 8'h00);
		@(posedge mclk);
		nrst <= 1'b0;
		repeat (3) @(posedge mclk);
		nrst <= 1'b1;
		rd(REG_POWER_FLAGS_REG, 8'h00);
		chk_val(pc_out, PC_RST, "pc after power reset");
		end_sim;
	end
endmodule // tb_core_status_pc_stack
`default_nettype wire

// ===== hdl/core_alu_flags.sv
// Result and flag generation for arithmetic, logic and rotate operations.
// Purely combinational; the caller registers what it keeps.
`timescale 1ns/1ns
`default_nettype none
module core_alu_flags
	import core_sfr_pkg::*;
(
	// Operation in
	input  wire exec_op_s op,
	// Result and flags out
	output alu_out_s      res
);

	function automatic logic [8:0] add9(input logic [7:0] x,
	                                    input logic [7:0] y,
	                                    input logic       ci);
		return {1'b0, x} + {1'b0, y} + {8'h00, ci};
	endfunction

	logic [7:0] opb;
	logic       ci;
	logic [8:0] full;
	logic [8:0] nib;

	always_comb begin
		opb  = (op.kind == OP_SUB) ? ~op.b : op.b;
		ci   = (op.kind == OP_SUB);
		full = add9(op.a, opb, ci);
		nib  = add9({4'h0, op.a[3:0]}, {4'h0, opb[3:0]}, ci);
		res  = '0;
		case (op.kind)
			OP_ADD, OP_SUB: begin
				res.result = full[7:0];
				res.c      = full[8];
				res.dc     = nib[4];
				res.z      = (full[7:0] == 8'h00);
				res.z_hit  = 1'b1;
				res.dc_hit = 1'b1;
				res.c_hit  = 1'b1;
			end
			OP_LOGIC: begin
				res.result = op.logic_res;
				res.z      = (op.logic_res == 8'h00);
				res.z_hit  = 1'b1;
			end
			OP_RLF: begin
				res.result = {op.a[6:0], op.c_in};
				res.c      = op.a[7];
				res.c_hit  = 1'b1;
			end
			OP_RRF: begin
				res.result = {op.c_in, op.a[7:1]};
				res.c      = op.a[0];
				res.c_hit  = 1'b1;
			end
			default: res.result = op.a;
		endcase
	end

endmodule // core_alu_flags
`default_nettype wire

// ===== hdl/core_sfr_pkg.sv
// Package for the core special-function block: register indices,
// field positions, reset values, operation codes and carrier structs.
// Assumes one core clock shared by the block and the execution unit.
package core_sfr_pkg;

	// Register indices on the plain register port
	localparam int unsigned ADDR_W = 3;
	localparam logic [2:0] REG_STATUS = 3'h0;
	localparam logic [2:0] REG_OPTION = 3'h1;
	localparam logic [2:0] REG_POWER_FLAGS_REG   = 3'h2;
	localparam logic [2:0] REG_PCL    = 3'h3;
	localparam logic [2:0] REG_PC_HIGH_LATCH = 3'h4;

	// Flag and bank register fields
	localparam int unsigned STAT_IRP   = 7;
	localparam int unsigned STAT_RP_HI = 6;
	localparam int unsigned STAT_RP_LO = 5;
	localparam int unsigned STAT_TO    = 4;
	localparam int unsigned STAT_PD    = 3;
	localparam int unsigned STAT_Z     = 2;
	localparam int unsigned STAT_DC    = 1;
	localparam int unsigned STAT_C     = 0;

	// Timer configuration fields
	localparam int unsigned OPT_PUD   = 7;
	localparam int unsigned OPT_EDG   = 6;
	localparam int unsigned OPT_CS    = 5;
	localparam int unsigned OPT_SE    = 4;
	localparam int unsigned OPT_PSA   = 3;
	localparam int unsigned OPT_PS_HI = 2;

	// Power flag fields
	localparam int unsigned POWER_FLAGS_REG_POR = 1;
	localparam int unsigned POWER_FLAGS_REG_BOR = 0;

	// Widths and reset values
	localparam int unsigned PC_W     = 13;
	localparam int unsigned LATCH_W  = 5;
	localparam int unsigned JUMP_W   = 11;
	localparam int unsigned PAGE_HI  = 4;
	localparam int unsigned PAGE_LO  = 3;
	localparam int unsigned PRESC_W  = 8;
	localparam logic [7:0]  OPTION_RST = 8'hff;
	localparam logic [4:0]  PC_HIGH_LATCH_RST = 5'h00;
	localparam logic [12:0] PC_RST     = 13'h0000;
	localparam logic [12:0] IRQ_VECTOR = 13'h0004;

	typedef enum logic [3:0] {
		OP_NONE, OP_ADD, OP_SUB, OP_LOGIC, OP_RLF, OP_RRF,
		OP_JUMP, OP_CALL, OP_RETURN, OP_IRQ, OP_WATCHDOG_CLEAR_INSTR, OP_SLEEP
	} op_kind_e;

	typedef struct packed {
		logic        valid;
		op_kind_e    kind;
		logic [7:0]  a;
		logic [7:0]  b;
		logic [7:0]  logic_res;
		logic        c_in;
		logic [10:0] target;
		logic        step;
	} exec_op_s;

	typedef struct packed {
		logic [7:0] result;
		logic       z;
		logic       dc;
		logic       c;
		logic       z_hit;
		logic       dc_hit;
		logic       c_hit;
	} alu_out_s;

	typedef struct packed {
		logic [8:0] indirect;
		logic [8:0] direct;
	} data_addr_s;

endpackage

// ===== hdl/core_status_pc_stack.sv
// Core flags, bank select, timer configuration, power flags, program
// counter and circular return stack. Driven by the execution unit on
// the core clock; pins are synchronised here.
`timescale 1ns/1ns
`default_nettype none
module core_status_pc_stack
	import core_sfr_pkg::*;
#(
	parameter int unsigned STACK_DEPTH = 8,
	parameter int unsigned SP_W        = 3
) (
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              nrst,
	// Register port
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [7:0]        reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [7:0]        reg_rdata,
	// Execution unit
	input  wire exec_op_s          exec_op,
	input  wire logic [7:0]        fsr,
	input  wire logic [6:0]        dir_offset,
	output logic      [7:0]        alu_result,
	output logic      [PC_W-1:0]   pc_out,
	output data_addr_s             data_addr,
	// Reset and watchdog events
	input  wire logic              wdt_timeout,
	input  wire logic              bor_event,
	input  wire logic              other_reset,
	// Timer, interrupt and pull-up side
	input  wire logic              timer0_ext_clock_pin,
	input  wire logic              ext_interrupt_pin,
	input  wire logic              instr_tick,
	input  wire logic              wdt_base_tick,
	input  wire logic [7:0]        pullup_enable_mask,
	output logic      [7:0]        pullup_en,
	output logic                   timer0_inc,
	output logic                   wdt_tick,
	output logic                   ext_irq
);

	typedef struct packed {
		logic             indirect_bank_select;
		logic [1:0]       rp;
		logic             to;
		logic             pd;
		logic             z;
		logic             dc;
		logic             c;
		logic [7:0]       option;
		logic             por;
		logic             bor;
		logic [4:0]       pc_high_latch;
		logic [PC_W-1:0]  pc;
		logic [SP_W-1:0]  sp;
		logic [PRESC_W-1:0] pscnt;
		logic [2:0]       t0pin;
		logic [2:0]       irqpin;
		logic [7:0]       rdata;
		logic [7:0]       alu_res;
		logic [7:0]       pullup_en;
		logic             t0_inc;
		logic             wdt_tick;
		logic             ext_irq;
		data_addr_s       addr;
	} core_state_s;

	localparam core_state_s STATE_RST = '{
		to: 1'b1, pd: 1'b1, option: OPTION_RST, pc_high_latch: PC_HIGH_LATCH_RST,
		pc: PC_RST, default: '0};

	function automatic logic [7:0] rate_mask(input logic [3:0] sh);
		logic [8:0] m9;
		m9 = (9'h001 << sh) - 9'h001;
		return m9[7:0];
	endfunction

	core_state_s     st_q;
	core_state_s     d;
	alu_out_s        alu;
	logic [PC_W-1:0] stack_top;
	logic            push;
	logic            pop;
	logic [SP_W-1:0] top_addr;
	logic            wr_st;
	logic            pcl_wr;
	logic            hw_rst;
	logic            t0_src;
	logic            ps_src;
	logic            ps_done;
	logic [7:0]      ps_mask;
	logic [3:0]      t0_sh;
	logic [3:0]      wdt_sh;

	core_alu_flags u_alu (
		.op  (exec_op),
		.res (alu)
	);

	return_stack_ram #(
		.DEPTH (STACK_DEPTH),
		.WIDTH (PC_W),
		.AW    (SP_W)
	) u_stack (
		.mclk    (mclk),
		.nrst    (nrst),
		.we      (push),
		.waddr   (st_q.sp),
		.wdata   (st_q.pc),
		.raddr   (top_addr),
		.rdata_q (stack_top)
	);

	always_comb begin
		d      = st_q;
		wr_st  = reg_wr && (reg_addr == REG_STATUS);
		pcl_wr = reg_wr && (reg_addr == REG_PCL);
		hw_rst = bor_event || other_reset;
		push   = 1'b0;
		pop    = 1'b0;

		// Pin synchronisers, third stage only for edge detection
		d.t0pin  = {st_q.t0pin[1:0], timer0_ext_clock_pin};
		d.irqpin = {st_q.irqpin[1:0], ext_interrupt_pin};

		// Register writes
		if (reg_wr) begin
			case (reg_addr)
				REG_STATUS: begin
					d.indirect_bank_select = reg_wdata[STAT_IRP];
					d.rp  = reg_wdata[STAT_RP_HI:STAT_RP_LO];
					d.z   = reg_wdata[STAT_Z];
					d.dc  = reg_wdata[STAT_DC];
					d.c   = reg_wdata[STAT_C];
				end
				REG_OPTION: d.option = reg_wdata;
				REG_POWER_FLAGS_REG: begin
					d.por = reg_wdata[POWER_FLAGS_REG_POR];
					d.bor = reg_wdata[POWER_FLAGS_REG_BOR];
				end
				REG_PCL:    d.pc = {st_q.pc_high_latch, reg_wdata};
				REG_PC_HIGH_LATCH: d.pc_high_latch = reg_wdata[LATCH_W-1:0];
				default: ;
			endcase
		end

		// Execution unit operation
		if (exec_op.valid) begin
			d.alu_res = alu.result;
			if (alu.z_hit) begin
				d.z = alu.z;
			end
			if (alu.dc_hit) begin
				d.dc = alu.dc;
			end
			if (alu.c_hit) begin
				d.c = alu.c;
			end
			if (exec_op.step && !pcl_wr) begin
				d.pc = st_q.pc + 13'h0001;
			end
			case (exec_op.kind)
				OP_JUMP: begin
					if (!pcl_wr) begin
						d.pc = {st_q.pc_high_latch[PAGE_HI:PAGE_LO],
						        exec_op.target};
					end
				end
				OP_CALL: begin
					push = 1'b1;
					if (!pcl_wr) begin
						d.pc = {st_q.pc_high_latch[PAGE_HI:PAGE_LO],
						        exec_op.target};
					end
				end
				OP_IRQ: begin
					push = 1'b1;
					d.pc = IRQ_VECTOR;
				end
				OP_RETURN: begin
					pop  = 1'b1;
					d.pc = stack_top;
				end
				OP_WATCHDOG_CLEAR_INSTR: begin
					d.to = 1'b1;
					d.pd = 1'b1;
				end
				OP_SLEEP: begin
					d.to = 1'b1;
					d.pd = 1'b0;
				end
				default: ;
			endcase
		end

		// Pointer wraps freely in both directions
		if (push) begin
			d.sp = st_q.sp + 3'h1;
		end else if (pop) begin
			d.sp = st_q.sp - 3'h1;
		end

		if (wdt_timeout) begin
			d.to = 1'b0;
		end

		// Brown-out or other non-power reset; a watchdog timeout only clears the timeout flag
		if (hw_rst) begin
			d.pc     = PC_RST;
			d.indirect_bank_select    = 1'b0;
			d.rp     = 2'b00;
			d.option = OPTION_RST;
			d.pc_high_latch = PC_HIGH_LATCH_RST;
			push     = 1'b0;
			d.sp     = st_q.sp;
		end
		if (bor_event) begin
			d.to  = 1'b1;
			d.pd  = 1'b1;
			d.bor = 1'b0;
		end

		// Timer0 source and prescaler
		t0_src = st_q.option[OPT_CS] ?
			(st_q.option[OPT_SE] ?
				(!st_q.t0pin[1] && st_q.t0pin[2]) :
				(st_q.t0pin[1] && !st_q.t0pin[2])) :
			instr_tick;
		t0_sh   = {1'b0, st_q.option[OPT_PS_HI:0]} + 4'h1;
		wdt_sh  = {1'b0, st_q.option[OPT_PS_HI:0]};
		ps_src  = st_q.option[OPT_PSA] ? wdt_base_tick : t0_src;
		ps_mask = st_q.option[OPT_PSA] ? rate_mask(wdt_sh) :
		          rate_mask(t0_sh);
		ps_done = ps_src && ((st_q.pscnt & ps_mask) == ps_mask);
		if (ps_src) begin
			d.pscnt = ps_done ? '0 : st_q.pscnt + 8'h01;
		end
		d.t0_inc   = st_q.option[OPT_PSA] ? t0_src : ps_done;
		d.wdt_tick = st_q.option[OPT_PSA] ? ps_done : wdt_base_tick;

		// External interrupt edge
		d.ext_irq = st_q.option[OPT_EDG] ?
			(st_q.irqpin[1] && !st_q.irqpin[2]) :
			(!st_q.irqpin[1] && st_q.irqpin[2]);

		d.pullup_en = st_q.option[OPT_PUD] ? 8'h00 :
		              pullup_enable_mask;
		d.addr.indirect = {st_q.indirect_bank_select, fsr};
		d.addr.direct   = {st_q.rp, dir_offset};

		// Register reads
		if (reg_rd) begin
			case (reg_addr)
				REG_STATUS: d.rdata = {st_q.indirect_bank_select, st_q.rp, st_q.to,
				                       st_q.pd, st_q.z, st_q.dc, st_q.c};
				REG_OPTION: d.rdata = st_q.option;
				REG_POWER_FLAGS_REG:   d.rdata = {6'h00, st_q.por, st_q.bor};
				REG_PCL:    d.rdata = st_q.pc[7:0];
				REG_PC_HIGH_LATCH: d.rdata = {3'h0, st_q.pc_high_latch};
				default:    d.rdata = 8'h00;
			endcase
		end
	end

	assign top_addr = d.sp - 3'h1;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st_q <= STATE_RST;
		end else begin
			st_q <= d;
		end
	end

	assign reg_rdata  = st_q.rdata;
	assign alu_result = st_q.alu_res;
	assign pc_out     = st_q.pc;
	assign data_addr  = st_q.addr;
	assign pullup_en  = st_q.pullup_en;
	assign timer0_inc = st_q.t0_inc;
	assign wdt_tick   = st_q.wdt_tick;
	assign ext_irq    = st_q.ext_irq;

	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	logic pd_evt;
	assign pd_evt = wdt_timeout || bor_event ||
		(exec_op.valid && (exec_op.kind inside {OP_WATCHDOG_CLEAR_INSTR, OP_SLEEP}));

	a_flags_override: assert property (
		wr_st && exec_op.valid && exec_op.kind == OP_ADD
		|=> st_q.z == $past(alu.z) && st_q.c == $past(alu.c))
		else $error("written flags not overridden");
	a_to_pd_locked: assert property (
		wr_st && !pd_evt |=> $stable(st_q.to) && $stable(st_q.pd))
		else $error("expiry or sleep flag written");
	a_sleep_flags: assert property (
		exec_op.valid && exec_op.kind == OP_SLEEP && !wdt_timeout &&
		!bor_event |=> st_q.to && !st_q.pd)
		else $error("sleep flags wrong");
	a_timeout_flag: assert property (
		wdt_timeout && !bor_event |=> !st_q.to)
		else $error("timeout did not clear flag");
	a_rotate_carry: assert property (
		exec_op.valid && exec_op.kind == OP_RLF
		|=> st_q.c == $past(exec_op.a[7]))
		else $error("rotate carry wrong");
	a_pullup_off: assert property (
		st_q.option[OPT_PUD] |=> pullup_en == 8'h00)
		else $error("pull-ups not disabled");
	a_wdt_rate: assert property (
		st_q.option[OPT_PSA] && st_q.option[OPT_PS_HI:0] == 3'b000 &&
		wdt_base_tick |=> wdt_tick)
		else $error("watchdog not undivided");
	a_bor_flag: assert property (
		bor_event |=> !st_q.bor && pc_out == PC_RST)
		else $error("brown-out reset effects missing");
	a_pcl_load: assert property (
		pcl_wr && !hw_rst |=> pc_out == {$past(st_q.pc_high_latch),
		                                  $past(reg_wdata)})
		else $error("low-byte write load wrong");
	a_jump_page: assert property (
		exec_op.valid && exec_op.kind == OP_JUMP && !pcl_wr && !hw_rst
		|=> pc_out[PC_W-1:PC_W-2] == $past(st_q.pc_high_latch[PAGE_HI:PAGE_LO]))
		else $error("jump page bits wrong");
	a_call_return: assert property (
		exec_op.valid && exec_op.kind == OP_CALL && !hw_rst && !pcl_wr
		##1 exec_op.valid && exec_op.kind == OP_RETURN && !hw_rst
		&& !pcl_wr |=> pc_out == $past(st_q.pc, 2))
		else $error("return address wrong");
	a_latch_kept: assert property (
		exec_op.valid && exec_op.kind == OP_RETURN && !hw_rst &&
		!(reg_wr && reg_addr == REG_PC_HIGH_LATCH) |=> $stable(st_q.pc_high_latch))
		else $error("latch changed on return");

	c_call_ret: cover property (exec_op.valid && exec_op.kind == OP_CALL
		##[1:20] exec_op.valid && exec_op.kind == OP_RETURN);
	c_sleep:    cover property (exec_op.valid && exec_op.kind == OP_SLEEP);
	c_pcl_wr:   cover property (pcl_wr);

endmodule // core_status_pc_stack
`default_nettype wire

// ===== hdl/return_stack_ram.sv
// Small memory for the return-address stack, registered read data.
// A write to the address being read is forwarded into the read register.
`timescale 1ns/1ns
`default_nettype none
module return_stack_ram #(
	parameter int unsigned DEPTH = 8,
	parameter int unsigned WIDTH = 13,
	parameter int unsigned AW    = 3
) (
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             nrst,
	// Write port
	input  wire logic             we,
	input  wire logic [AW-1:0]    waddr,
	input  wire logic [WIDTH-1:0] wdata,
	// Read port
	input  wire logic [AW-1:0]    raddr,
	output logic      [WIDTH-1:0] rdata_q
);

	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge mclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= '0;
		end else if (we && (waddr == raddr)) begin
			rdata_q <= wdata;
		end else begin
			rdata_q <= mem[raddr];
		end
	end

endmodule // return_stack_ram
`default_nettype wire
